// file: design/ecw_params.svh
// constants for the echo canceller write register bank
`ifndef ECW_PARAMS_SVH
`define ECW_PARAMS_SVH
`define ECW_OFF_LOCK 8'h01
`define ECW_OFF_WATCHDOG_KEY_FIRST 8'h02
`define ECW_OFF_WATCHDOG_KEY_SECOND 8'h03
`define ECW_OFF_WATCHDOG_KEY_THIRD 8'h04
`define ECW_OFF_LOOP 8'h06
`define ECW_OFF_MASK 8'h07
`define ECW_OFF_TSMON 8'h2F
`define ECW_OFF_GCFG 8'h30
`define ECW_OFF_STATUS 8'h80
`define ECW_OFF_IRQREQ 8'h81
`define ECW_OFF_MONDATA 8'h82
`define ECW_OFF_EVENTS 8'h83
`define ECW_KEY_UNLOCK 8'h95
`define ECW_KEY_WATCHDOG_KEY_FIRST 8'hAA
`define ECW_KEY_WATCHDOG_KEY_SECOND 8'h99
`define ECW_KEY_WATCHDOG_KEY_THIRD 8'h1D
`define ECW_RST_LOOP 4'h0
`define ECW_RST_MASK 7'h7F
`define ECW_RST_TSMON 7'h00
`define ECW_RST_GCFG 8'h03
`define ECW_BIT_SNAP 6
`define ECW_BIT_MREQ 5
`define ECW_SRC_WDOG 6
`define ECW_SRC_TSM 0
`define ECW_BIT_SEND_TO_RECEIVE_LOOP 3
`define ECW_BIT_RECEIVE_TO_SEND_LOOP 2
`define ECW_BIT_RBYP 1
`define ECW_BIT_SBYP 0
`define ECW_BIT_SATTEN 5
`define ECW_BIT_SATTMOD 4
`define ECW_BIT_RATTEN 3
`define ECW_BIT_RATTMOD 2
`define ECW_BIT_DYNAMIC_SUBTRACTOR 1
`define ECW_BIT_ERRINV 0
`define ECW_WDG_WINDOW_MS 2000
`define ECW_CLK_HZ 10000000
`define ECW_WDG_CYCLES ((`ECW_WDG_WINDOW_MS * (`ECW_CLK_HZ / 1000)))
`endif

// file: design/ecw_pkg.sv
// types for the echo canceller write register bank
`default_nettype none
package ecw_pkg;
    typedef enum logic [1:0] {WDG_IDLE, WDG_GOT1, WDG_GOT2} ecw_wdg_t;
endpackage : ecw_pkg
`default_nettype wire

// file: design/ecw_regs.sv
// echo canceller write-only register bank with monitor, mask, lock and watchdog
// Operation
// R1: registers are write only; reads never return stored contents
// R2: hold mode refreshes monitor once per request, holds data, flags valid
// R3: hold mode poll flag clears only when a new request starts
// R4: continuous mode updates every selected slot, interrupt only first time
// R5: request written zero clears poll condition, stops continuous updates
// R6: request captures slot of five-bit select, flags status and request
// R7: unlock key 95H opens protected writes, other value locks; locked at reset
// R8: masked source shows in status, not in request; mask resets to 7FH
// R9: masking leaves source alone; unmask of active source raises interrupt
// R10: each mask bit suppresses its own one of seven sources
// R11: host writes watchdog keys AAH, 99H, 1DH in order
// R12: host completes watchdog key sequence within two seconds
// R13: missed or wrong watchdog sequence raises watchdog status and interrupt
// R14: send-to-receive loop routes send output into receive input
// R15: receive-to-send loop routes receive output into send input
// R16: both loops set means only receive-to-send loop acts
// R17: receive bypass passes receive input straight to receive output
// R18: send bypass passes send input straight to send output
// R19: send attenuation follows channel enable, level bit selects 2.5 or 6 dB
// R20: receive attenuation follows channel enable, level bit selects 2.5 or 6 dB
// R21: dynamic subtractor bit selects dynamic or linear subtractor
// R22: error sign invert bit inverts error sign, clear is test only
// R23: while locked, writes to loop and global config registers are ignored
//
// The implementer's own choice: register access over Avalon-MM.
`default_nettype none
`include "ecw_params.svh"
module ecw_regs
    import ecw_pkg::*;
#(
    parameter int WDG_CYCLES = `ECW_WDG_CYCLES
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic slot_strobe,
    input wire logic [4:0] slot_number,
    input wire logic [7:0] slot_data,
    input wire logic [5:0] src_events,
    input wire logic [7:0] send_in,
    input wire logic [7:0] send_proc,
    input wire logic [7:0] receive_in,
    input wire logic [7:0] receive_proc,
    input wire logic chan_ec_enable,
    output logic [7:0] send_out,
    output logic [7:0] receive_out,
    output logic send_path_feed_sel,
    output logic receive_path_feed_sel,
    output logic send_atten_active,
    output logic send_atten_level,
    output logic receive_atten_active,
    output logic receive_atten_level,
    output logic dynamic_subtractor,
    output logic error_sign_invert,
    output logic irq_out
);
    logic unlocked_r;
    logic [3:0] loop_bypass_control_r;
    logic [6:0] interrupt_source_mask_r;
    logic [6:0] timeslot_monitor_control_r;
    logic [7:0] global_output_config_r;
    logic [7:0] monitor_data_r;
    logic monitor_poll_flag_r;
    logic monitor_done_r;
    logic [6:0] status_r;
    logic [6:0] interrupt_request_reg_r;
    logic [6:0] src_now;
    logic [6:0] irq_nxt;
    logic [6:0] mask_nxt;
    logic wdog_fault_r;
    ecw_wdg_t wdg_state_r;
    logic [31:0] wdg_cnt_r;
    logic ack_r;
    logic wr_go;
    logic rd_go;
    logic capture;
    logic mreq_wr;
    logic mreq_clr;
    logic [7:0] wdat;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    // one wait cycle per access keeps every answer registered
    assign wr_go = avs_write && ack_r;
    assign rd_go = avs_read && ack_r;
    assign wdat = avs_writedata[7:0];
    assign mreq_wr = wr_go && hit(avs_address, `ECW_OFF_TSMON);
    assign mreq_clr = mreq_wr && !wdat[`ECW_BIT_MREQ];

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read || avs_write) && !ack_r;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && !ack_r);
        end
    end

    // R1: write only readback
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && !ack_r) begin
            if (hit(avs_address, `ECW_OFF_STATUS)) begin
                avs_readdata <= {25'h0000000, status_r};
            end else if (hit(avs_address, `ECW_OFF_IRQREQ)) begin
                avs_readdata <= {25'h0000000, interrupt_request_reg_r};
            end else if (hit(avs_address, `ECW_OFF_MONDATA)) begin
                avs_readdata <= {23'h000000, monitor_poll_flag_r, monitor_data_r};
            end else begin
                avs_readdata <= 32'h00000000;
            end
        end
    end

    // R7: unlock key handling
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            unlocked_r <= 1'b0;
        end else if (wr_go && hit(avs_address, `ECW_OFF_LOCK)) begin
            unlocked_r <= (wdat == `ECW_KEY_UNLOCK);
        end
    end

    // R23: protected writes gated
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            loop_bypass_control_r <= `ECW_RST_LOOP;
        end else if (wr_go && unlocked_r && hit(avs_address, `ECW_OFF_LOOP)) begin
            loop_bypass_control_r <= wdat[3:0];
        end
    end

    // R23: protected writes gated
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            global_output_config_r <= `ECW_RST_GCFG;
        end else if (wr_go && unlocked_r && hit(avs_address, `ECW_OFF_GCFG)) begin
            global_output_config_r <= wdat;
        end
    end

    // R8: mask reset value
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            interrupt_source_mask_r <= `ECW_RST_MASK;
        end else if (wr_go && hit(avs_address, `ECW_OFF_MASK)) begin
            interrupt_source_mask_r <= wdat[6:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            timeslot_monitor_control_r <= `ECW_RST_TSMON;
        end else if (mreq_wr) begin
            timeslot_monitor_control_r <= wdat[6:0];
        end
    end

    // R6: capture selected slot; R2/R4 hold versus continuous
    assign capture = slot_strobe && timeslot_monitor_control_r[`ECW_BIT_MREQ] && !mreq_wr
        && (slot_number == timeslot_monitor_control_r[4:0])
        && !(timeslot_monitor_control_r[`ECW_BIT_SNAP] && monitor_done_r);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            monitor_data_r <= 8'h00;
        end else if (capture) begin
            monitor_data_r <= slot_data;
        end
    end

    // R2: one capture per request in hold mode
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            monitor_done_r <= 1'b0;
        end else if (mreq_wr) begin
            monitor_done_r <= 1'b0;
        end else if (capture) begin
            monitor_done_r <= 1'b1;
        end
    end

    // R3: poll flag cleared by new request; R5: cleared by zero write; set wins
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            monitor_poll_flag_r <= 1'b0;
        end else if (capture && !monitor_done_r) begin
            monitor_poll_flag_r <= 1'b1;
        end else if (mreq_wr) begin
            monitor_poll_flag_r <= 1'b0;
        end
    end

    // R13: watchdog key sequence and window
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wdg_state_r <= WDG_IDLE;
        end else if (wr_go && hit(avs_address, `ECW_OFF_WATCHDOG_KEY_FIRST)) begin
            wdg_state_r <= (wdat == `ECW_KEY_WATCHDOG_KEY_FIRST) ? WDG_GOT1 : WDG_IDLE;
        end else if (wr_go && hit(avs_address, `ECW_OFF_WATCHDOG_KEY_SECOND)) begin
            wdg_state_r <= (wdg_state_r == WDG_GOT1 && wdat == `ECW_KEY_WATCHDOG_KEY_SECOND) ? WDG_GOT2 : WDG_IDLE;
        end else if (wr_go && hit(avs_address, `ECW_OFF_WATCHDOG_KEY_THIRD)) begin
            wdg_state_r <= WDG_IDLE;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wdg_cnt_r <= 32'h00000000;
        end else if (wr_go && hit(avs_address, `ECW_OFF_WATCHDOG_KEY_THIRD) && wdg_state_r == WDG_GOT2
                && wdat == `ECW_KEY_WATCHDOG_KEY_THIRD) begin
            wdg_cnt_r <= 32'h00000000;
        end else if (wdg_cnt_r < WDG_CYCLES[31:0]) begin
            wdg_cnt_r <= wdg_cnt_r + 32'h00000001;
        end
    end

    // pulse once when the window runs out; a wrong key simply fails to restart it
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wdog_fault_r <= 1'b0;
        end else begin
            wdog_fault_r <= (wdg_cnt_r == WDG_CYCLES[31:0] - 32'h00000001);
        end
    end

    assign src_now = {wdog_fault_r, src_events[4:0], 1'b0};

    // R8: status holds conditions regardless of mask; set wins over clear
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            status_r <= 7'h00;
        end else begin
            status_r[6:1] <= src_now[6:1] | (status_r[6:1] & ~(wr_go && hit(avs_address, `ECW_OFF_EVENTS)
                ? wdat[6:1] : 6'h00));
            status_r[`ECW_SRC_TSM] <= monitor_poll_flag_r;
        end
    end

    // R9: unmasked active status reasserts request; R10: per-source mask
    // a mask write acts on the request in its own cycle, so a masked source never lingers there
    always_comb begin
        mask_nxt = (wr_go && hit(avs_address, `ECW_OFF_MASK)) ? wdat[6:0] : interrupt_source_mask_r;
        irq_nxt = status_r & ~mask_nxt;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            interrupt_request_reg_r <= 7'h00;
        end else begin
            interrupt_request_reg_r <= irq_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |irq_nxt;
        end
    end

    // R16: receive-to-send loop wins; R14, R15 feed selects
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            send_path_feed_sel <= 1'b0;
            receive_path_feed_sel <= 1'b0;
        end else begin
            send_path_feed_sel <= loop_bypass_control_r[`ECW_BIT_RECEIVE_TO_SEND_LOOP];
            receive_path_feed_sel <= loop_bypass_control_r[`ECW_BIT_SEND_TO_RECEIVE_LOOP]
                && !loop_bypass_control_r[`ECW_BIT_RECEIVE_TO_SEND_LOOP];
        end
    end

    // R17, R18: path bypass muxes
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            send_out <= 8'h00;
            receive_out <= 8'h00;
        end else begin
            send_out <= loop_bypass_control_r[`ECW_BIT_SBYP] ? send_in : send_proc;
            receive_out <= loop_bypass_control_r[`ECW_BIT_RBYP] ? receive_in : receive_proc;
        end
    end

    // R19, R20: attenuation follows channel enable
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            send_atten_active <= 1'b0;
            send_atten_level <= 1'b0;
            receive_atten_active <= 1'b0;
            receive_atten_level <= 1'b0;
        end else begin
            send_atten_active <= global_output_config_r[`ECW_BIT_SATTEN] && chan_ec_enable;
            send_atten_level <= global_output_config_r[`ECW_BIT_SATTMOD];
            receive_atten_active <= global_output_config_r[`ECW_BIT_RATTEN] && chan_ec_enable;
            receive_atten_level <= global_output_config_r[`ECW_BIT_RATTMOD];
        end
    end

    // R21, R22: subtractor and error sign
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            dynamic_subtractor <= 1'b1;
            error_sign_invert <= 1'b1;
        end else begin
            dynamic_subtractor <= global_output_config_r[`ECW_BIT_DYNAMIC_SUBTRACTOR];
            error_sign_invert <= global_output_config_r[`ECW_BIT_ERRINV];
        end
    end

    // R23: locked loop writes do nothing
    AST_LOCK_BLOCKS: assert property (@(posedge mclk) disable iff (sys_rst) // R23
        (wr_go && !unlocked_r && hit(avs_address, `ECW_OFF_LOOP)) |=> $stable(loop_bypass_control_r))
        else $error("loop register changed while locked");
    // R23: locked config write ignored
    AST_GCFG_LOCKED: assert property (@(posedge mclk) disable iff (sys_rst) // R23
        (wr_go && !unlocked_r && hit(avs_address, `ECW_OFF_GCFG)) |=> $stable(global_output_config_r))
        else $error("config register changed while locked");
    // R7: other key relocks
    AST_WRONG_KEY_LOCKS: assert property (@(posedge mclk) disable iff (sys_rst) // R7
        (wr_go && hit(avs_address, `ECW_OFF_LOCK) && wdat != `ECW_KEY_UNLOCK) |=> !unlocked_r)
        else $error("wrong key left writes unlocked");
    // R8: masked source never requests
    AST_MASK_SUPPRESS: assert property (@(posedge mclk) disable iff (sys_rst) // R8
        (interrupt_request_reg_r & interrupt_source_mask_r) == 7'h00)
        else $error("masked source in request register");
    // R9: unmask of active source 1 raises request
    AST_UNMASK_REASSERT: assert property (@(posedge mclk) disable iff (sys_rst) // R9
        (status_r[1] && !mask_nxt[1]) |=> interrupt_request_reg_r[1])
        else $error("active unmasked source not requested");
    // R16: both loops
    AST_LOOP_PRIORITY: assert property (@(posedge mclk) disable iff (sys_rst) // R16
        !(send_path_feed_sel && receive_path_feed_sel))
        else $error("both loops active");
    // R2: hold mode captures once
    AST_HOLD_ONCE: assert property (@(posedge mclk) disable iff (sys_rst) // R2
        (timeslot_monitor_control_r[`ECW_BIT_SNAP] && monitor_done_r && !mreq_wr) |=> $stable(monitor_data_r))
        else $error("hold mode data overwritten");
    // R5: zero request clears poll
    AST_MREQ_CLEAR: assert property (@(posedge mclk) disable iff (sys_rst) // R5
        (mreq_clr && !capture) |=> !monitor_poll_flag_r ##1 !status_r[`ECW_SRC_TSM])
        else $error("poll flag not cleared");
    // R6: capture flags status within two cycles
    AST_CAPTURE_FLAG: assert property (@(posedge mclk) disable iff (sys_rst) // R6
        capture |=> monitor_poll_flag_r ##1 status_r[`ECW_SRC_TSM])
        else $error("capture not flagged");
    // R1: stored config never read back
    AST_WRITE_ONLY: assert property (@(posedge mclk) disable iff (sys_rst) // R1
        (rd_go && hit(avs_address, `ECW_OFF_GCFG)) |-> avs_readdata == 32'h00000000)
        else $error("write only register read back");
    // R13: expired window flags watchdog status
    AST_WDOG_FLAG: assert property (@(posedge mclk) disable iff (sys_rst) // R13
        wdog_fault_r |=> status_r[`ECW_SRC_WDOG])
        else $error("watchdog status not set");
    // R13: full key sequence restarts window
    AST_WDOG_RESTART: assert property (@(posedge mclk) disable iff (sys_rst) // R13
        (wr_go && hit(avs_address, `ECW_OFF_WATCHDOG_KEY_THIRD) && wdg_state_r == WDG_GOT2 && wdat == `ECW_KEY_WATCHDOG_KEY_THIRD)
        |=> wdg_cnt_r == 32'h00000000)
        else $error("watchdog window not restarted");
endmodule : ecw_regs
`default_nettype wire

// file: testbench/ecw_regs_bench.sv
// self-checking bench for the echo canceller write register bank
`default_nettype none
`include "ecw_params.svh"
module ecw_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] adr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic wrq;
    logic stb = 1'b0;
    logic [4:0] slot = 5'h00;
    logic [7:0] sdat = 8'h00;
    logic [5:0] ev = 6'h00;
    logic [7:0] s_in = 8'h00, s_pr = 8'h00, r_in = 8'h00, r_pr = 8'h00;
    logic ec_en = 1'b0;
    logic [7:0] s_out, r_out;
    logic s_sel, r_sel, s_act, s_lvl, r_act, r_lvl, dyn, inv, irq;
    int failures = 0;
    int cmp_count = 0;
    // behavioural model state
    logic [6:0] m_stat = 7'h00, m_mask = 7'h7F, view = 7'h3F;
    logic [3:0] m_loop = 4'h0;
    logic [7:0] m_cfg = 8'h03, m_mon = 8'h00;
    logic m_lock = 1'b1, m_req = 1'b0, m_snap = 1'b0, m_got = 1'b0;
    logic [4:0] m_ch = 5'h00;
    logic [31:0] q;
    logic [7:0] offs [9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h2F, 8'h30, 8'h55};
    // sim-sized watchdog window, 2 s would be far too long
    ecw_regs #(.WDG_CYCLES(200)) i_ecw_regs (.mclk(mclk), .sys_rst(sys_rst), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wrq),
        .slot_strobe(stb), .slot_number(slot), .slot_data(sdat), .src_events(ev), .send_in(s_in),
        .send_proc(s_pr), .receive_in(r_in), .receive_proc(r_pr), .chan_ec_enable(ec_en), .send_out(s_out),
        .receive_out(r_out), .send_path_feed_sel(s_sel), .receive_path_feed_sel(r_sel),
        .send_atten_active(s_act), .send_atten_level(s_lvl), .receive_atten_active(r_act),
        .receive_atten_level(r_lvl), .dynamic_subtractor(dyn), .error_sign_invert(inv), .irq_out(irq));
    always #50 mclk = ~mclk;
    task automatic wrap_up();
        if (failures == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // request held until waitrequest is sampled low
    task automatic bus(input logic is_wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        adr <= a;
        wdat <= {24'h000000, d};
        rd <= ~is_wr;
        wr <= is_wr;
        do begin
            @(posedge mclk);
            n++;
        end while (wrq !== 1'b0 && n < 50);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        check("waitrequest", {31'h0, wrq}, 32'h0);
    endtask : bus
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
        case (a)
            // unlock key, any other value locks
            `ECW_OFF_LOCK: m_lock = (d != `ECW_KEY_UNLOCK);
            `ECW_OFF_LOOP: if (!m_lock) m_loop = d[3:0];
            `ECW_OFF_GCFG: if (!m_lock) m_cfg = d;
            `ECW_OFF_MASK: m_mask = d[6:0];
            `ECW_OFF_EVENTS: m_stat = m_stat & ~{d[6:1], 1'b0};
            `ECW_OFF_TSMON: begin
                m_stat[0] = 1'b0;
                m_req = d[5];
                m_snap = d[6];
                m_ch = d[4:0];
                m_got = 1'b0;
            end
            default: ;
        endcase
    endtask : wreg
    task automatic chk_out();
        repeat (3) @(posedge mclk);
        check("send_out", s_out, m_loop[0] ? s_in : s_pr);
        check("receive_out", r_out, m_loop[1] ? r_in : r_pr);
        check("send_feed", s_sel, m_loop[2]);
        check("receive_feed", r_sel, m_loop[3] & ~m_loop[2]);
        check("send_att", {s_act, s_lvl}, {m_cfg[5] & ec_en, m_cfg[4]});
        check("recv_att", {r_act, r_lvl}, {m_cfg[3] & ec_en, m_cfg[2]});
        check("dynamic_subtractor", dyn, m_cfg[1]);
        check("errinv", inv, m_cfg[0]);
        check("irq", irq, |(m_stat & ~m_mask));
        bus(1'b0, `ECW_OFF_STATUS, 8'h00);
        check("status", q[6:0] & view, m_stat & view);
        bus(1'b0, `ECW_OFF_IRQREQ, 8'h00);
        check("irqreq", q[6:0] & view, m_stat & ~m_mask & view);
    endtask : chk_out
    task automatic fire(input int b);
        @(posedge mclk);
        ev <= 6'h01 << (b - 1);
        @(posedge mclk);
        ev <= 6'h00;
        m_stat[b] = 1'b1;
    endtask : fire
    task automatic slot_go(input logic [4:0] ch);
        logic [7:0] d;
        d = 8'($urandom);
        @(posedge mclk);
        stb <= 1'b1;
        slot <= ch;
        sdat <= d;
        @(posedge mclk);
        stb <= 1'b0;
        if (m_req && ch == m_ch && !(m_snap && m_got)) begin
            m_mon = d;
            m_stat[0] = 1'b1;
            m_got = 1'b1;
        end
        chk_out();
        bus(1'b0, `ECW_OFF_MONDATA, 8'h00);
        check("monitor", q[7:0], m_mon);
    endtask : slot_go
    task automatic wdg(input logic [7:0] k2);
        wreg(`ECW_OFF_WATCHDOG_KEY_FIRST, `ECW_KEY_WATCHDOG_KEY_FIRST);
        wreg(`ECW_OFF_WATCHDOG_KEY_SECOND, k2);
        wreg(`ECW_OFF_WATCHDOG_KEY_THIRD, `ECW_KEY_WATCHDOG_KEY_THIRD);
    endtask : wdg
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        wrap_up();
    end
    initial begin
        void'($urandom(14085));
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        chk_out();
        wreg(`ECW_OFF_LOOP, 8'h0F);
        wreg(`ECW_OFF_GCFG, 8'h00);
        chk_out();
        wreg(`ECW_OFF_LOCK, `ECW_KEY_UNLOCK);
        for (int i = 0; i < 16; i++) begin
            s_in <= 8'($urandom);
            s_pr <= 8'($urandom);
            r_in <= 8'($urandom);
            r_pr <= 8'($urandom);
            wreg(`ECW_OFF_LOOP, 8'(i));
            chk_out();
        end
        for (int i = 0; i < 8; i++) begin
            ec_en <= 1'($urandom);
            wreg(`ECW_OFF_GCFG, 8'($urandom));
            chk_out();
        end
        // relock with a near-miss key
        wreg(`ECW_OFF_LOCK, 8'h94);
        wreg(`ECW_OFF_LOOP, 8'h05);
        wreg(`ECW_OFF_GCFG, 8'h00);
        chk_out();
        // stored contents never read back, unmapped too
        foreach (offs[i]) begin
            bus(1'b0, offs[i], 8'h00);
            check("readback", q, 32'h0);
        end
        // each event source 1 to 5 fired while masked, then unmasked, then cleared, then masked again
        for (int b = 1; b < 6; b++) begin
            fire(b);
            chk_out();
            wreg(`ECW_OFF_MASK, 8'h7F & ~(8'h01 << b));
            chk_out();
            wreg(`ECW_OFF_EVENTS, 8'h01 << b);
            wreg(`ECW_OFF_MASK, 8'h7F);
            chk_out();
        end
        // hold mode: wrong slot, capture, then held
        wreg(`ECW_OFF_MASK, 8'h7E);
        wreg(`ECW_OFF_TSMON, 8'h67);
        slot_go(5'h03);
        slot_go(5'h07);
        slot_go(5'h07);
        // continuous mode updates, then stop
        wreg(`ECW_OFF_TSMON, 8'h3F);
        slot_go(5'h1F);
        slot_go(5'h1F);
        wreg(`ECW_OFF_TSMON, 8'h1F);
        slot_go(5'h1F);
        chk_out();
        // watchdog serviced in time keeps quiet
        view = 7'h7F;
        wreg(`ECW_OFF_MASK, 8'h3F);
        wdg(`ECW_KEY_WATCHDOG_KEY_SECOND);
        wreg(`ECW_OFF_EVENTS, 8'h40);
        for (int i = 0; i < 3; i++) begin
            repeat (120) @(posedge mclk);
            wdg(`ECW_KEY_WATCHDOG_KEY_SECOND);
        end
        chk_out();
        // wrong middle key lets the window run out
        wdg(8'h55);
        repeat (220) @(posedge mclk);
        m_stat[6] = 1'b1;
        chk_out();
        wrap_up();
    end
endmodule : ecw_regs_bench
`default_nettype wire
